// File: include/tmc_map.svh
// register offsets, field positions, reset values and timing counts for the timer channel block
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
`define TMC_ADDR_CTRL     4'h0
`define TMC_ADDR_MOD_LO   4'h1
`define TMC_ADDR_MOD_HI   4'h2
`define TMC_ADDR_CHSC     4'h3
`define TMC_ADDR_CHVAL_LO 4'h4
`define TMC_ADDR_CHVAL_HI 4'h5
`define TMC_ADDR_CNT_LO   4'h6
`define TMC_ADDR_CNT_HI   4'h7
`define TMC_BIT_FLAG      7
`define TMC_BIT_IE        6
`define TMC_BIT_MSB       5
`define TMC_BIT_MSA       4
`define TMC_BIT_ELSB      3
`define TMC_BIT_ELSA      2
`define TMC_BIT_OVF       7
`define TMC_BIT_CPWM      5
`define TMC_MOD_RESET     16'h0000
`define TMC_PRESCALE_DEF  8
`endif

// File: include/tmc_pkg.sv
// types shared by the timer channel block
package tmc_pkg;
    typedef enum logic [2:0] {
        TMC_MODE_OFF,
        TMC_MODE_CAPTURE,
        TMC_MODE_COMPARE,
        TMC_MODE_EPWM,
        TMC_MODE_CPWM
    } tmc_mode_e;
endpackage : tmc_pkg

// File: core/tmc_timer_channel.sv
// modulo counter and one capture/compare/pwm channel with byte register port
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_timer_channel #(
    parameter int PRESCALE = `TMC_PRESCALE_DEF  // bus clocks per counting tick
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_ch_pin,
    output logic            o_ch_pin,
    output logic            o_ch_pin_oe_n,
    output logic            o_ch_irq,
    output logic            o_ovf_irq,
    output tmc_pkg::tmc_mode_e o_mode
);
    import tmc_pkg::*;

    // register state
    logic [15:0] mod_q, mod_d;          // modulo value
    logic [7:0]  mod_lo_buf_q, mod_lo_buf_d;
    logic [7:0]  mod_hi_buf_q, mod_hi_buf_d;
    logic [1:0]  mod_half_q, mod_half_d;    // which bytes written so far
    logic [15:0] cnt_q, cnt_d;          // counter
    logic        down_q, down_d;        // centre mode direction
    logic        ovf_q, ovf_d;          // overflow flag
    logic        ovf_armed_q, ovf_armed_d;
    logic        ovf_ie_q, ovf_ie_d;
    logic        cpwm_q, cpwm_d;        // centre-align select
    logic        flag_q, flag_d;        // channel event flag
    logic        flag_armed_q, flag_armed_d; // flag read while set
    logic        ie_q, ie_d;
    logic [1:0]  ms_q, ms_d;            // mode b:a
    logic [1:0]  els_q, els_d;          // edge/level
    logic [15:0] chval_q, chval_d;      // channel value
    logic [7:0]  chval_lo_buf_q, chval_lo_buf_d;
    logic [1:0]  chval_half_q, chval_half_d;
    logic        pin_q, pin_d;          // driven pin level
    logic [7:0]  rdata_q, rdata_d;
    logic [2:0]  sync_q, sync_d;        // pin synchroniser
    logic        pin_prev_q, pin_prev_d;
    logic [7:0]  pre_q, pre_d;          // prescaler
    tmc_mode_e   mode;
    logic        tick;
    logic        at_top;
    logic        match;
    logic        rise, fall, edge_hit, event_hit, ovf_hit;
    logic        mod_inhibit;

    // mode decode
    always_comb begin
        if (cpwm_q) begin
            mode = (els_q == 2'b00) ? TMC_MODE_OFF : TMC_MODE_CPWM;
        end else if (ms_q[1]) begin
            mode = (els_q == 2'b00) ? TMC_MODE_OFF : TMC_MODE_EPWM;
        // mode a choice; compare with field zero stays a software timer
        end else if (ms_q[0]) begin
            mode = TMC_MODE_COMPARE;
        end else begin
            mode = (els_q == 2'b00) ? TMC_MODE_OFF : TMC_MODE_CAPTURE;
        end
    end

    // event detection; the first sync stage feeds only the second
    always_comb begin
        tick = (pre_q == 8'(PRESCALE - 1));
        at_top = (mod_q == 16'h0000) ? (cnt_q == 16'hffff) : (cnt_q == mod_q);
        match = tick && (cnt_q == chval_q);
        rise = sync_q[1] && sync_q[2] == sync_q[1] && !pin_prev_q;
        fall = !sync_q[1] && sync_q[2] == sync_q[1] && pin_prev_q;
        edge_hit = (els_q[0] && rise) || (els_q[1] && fall);
        mod_inhibit = (mod_half_q != 2'b00);
        ovf_hit = tick && at_top && !(cpwm_q && down_q);
        if (cpwm_q && (mod_q == 16'h0000)) begin
            ovf_hit = 1'b0;  // centre mode needs a modulo
        end
        case (mode)
            TMC_MODE_CAPTURE: event_hit = edge_hit;
            TMC_MODE_COMPARE: event_hit = match;
            TMC_MODE_EPWM:    event_hit = match;
            TMC_MODE_CPWM:    event_hit = match;
            default:          event_hit = 1'b0;
        endcase
    end

    // next-state for all registers
    always_comb begin
        mod_d = mod_q;
        mod_lo_buf_d = mod_lo_buf_q;
        mod_hi_buf_d = mod_hi_buf_q;
        mod_half_d = mod_half_q;
        cnt_d = cnt_q;
        down_d = down_q;
        ovf_d = ovf_q;
        ovf_armed_d = ovf_armed_q;
        ovf_ie_d = ovf_ie_q;
        cpwm_d = cpwm_q;
        flag_d = flag_q;
        flag_armed_d = flag_armed_q;
        ie_d = ie_q;
        ms_d = ms_q;
        els_d = els_q;
        chval_d = chval_q;
        chval_lo_buf_d = chval_lo_buf_q;
        chval_half_d = chval_half_q;
        pin_d = pin_q;
        rdata_d = 8'h00;
        sync_d = {sync_q[1:0], i_ch_pin};
        pin_prev_d = (sync_q[2] == sync_q[1]) ? sync_q[1] : pin_prev_q;
        pre_d = tick ? 8'h00 : pre_q + 8'h01;

        // counter
        if (tick) begin
            if (cpwm_q && mod_q != 16'h0000) begin
                if (!down_q && cnt_q >= mod_q) begin
                    down_d = 1'b1;
                    cnt_d = cnt_q - 16'h0001;
                end else if (down_q && cnt_q == 16'h0000) begin
                    down_d = 1'b0;
                    cnt_d = 16'h0001;
                end else begin
                    cnt_d = down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
                end
            end else if (at_top) begin
                cnt_d = 16'h0000;
                down_d = 1'b0;
            end else begin
                cnt_d = cnt_q + 16'h0001;
                down_d = 1'b0;
            end
        end

        // channel pin action
        if (match) begin
            case (mode)
                TMC_MODE_COMPARE: begin
                    case (els_q)
                        2'b00:   pin_d = pin_q;  // flag only, pin left alone
                        2'b01:   pin_d = !pin_q;
                        2'b10:   pin_d = 1'b0;
                        default: pin_d = 1'b1;
                    endcase
                end
                TMC_MODE_EPWM, TMC_MODE_CPWM: pin_d = els_q[0];
                default: pin_d = pin_q;
            endcase
        end
        if (tick && at_top && mode == TMC_MODE_EPWM) begin
            pin_d = !els_q[0];
        end
        // centre pwm returns to active on the down-count match
        if (match && mode == TMC_MODE_CPWM && down_q) begin
            pin_d = !els_q[0];
        end

        // reads; arming happens on a read that sees the flag set
        if (i_rd) begin
            case (i_addr)
                `TMC_ADDR_CTRL:     rdata_d = {ovf_q, ovf_ie_q, cpwm_q, 5'h00};
                `TMC_ADDR_MOD_LO:   rdata_d = mod_q[7:0];
                `TMC_ADDR_MOD_HI:   rdata_d = mod_q[15:8];
                `TMC_ADDR_CHSC:     rdata_d = {flag_q, ie_q, ms_q, els_q, 2'b00};
                `TMC_ADDR_CHVAL_LO: rdata_d = chval_q[7:0];
                `TMC_ADDR_CHVAL_HI: rdata_d = chval_q[15:8];
                `TMC_ADDR_CNT_LO:   rdata_d = cnt_q[7:0];
                `TMC_ADDR_CNT_HI:   rdata_d = cnt_q[15:8];
                default:            rdata_d = 8'h00;
            endcase
            if (i_addr == `TMC_ADDR_CHSC && flag_q) begin
                flag_armed_d = 1'b1;
            end
            if (i_addr == `TMC_ADDR_CTRL && ovf_q) begin
                ovf_armed_d = 1'b1;
            end
        end

        // writes
        if (i_wr) begin
            case (i_addr)
                `TMC_ADDR_CTRL: begin
                    ovf_ie_d = i_wdata[6];
                    cpwm_d = i_wdata[`TMC_BIT_CPWM];
                    if (!i_wdata[`TMC_BIT_OVF] && ovf_armed_q) begin
                        ovf_d = 1'b0;
                    end
                    ovf_armed_d = 1'b0;
                end
                `TMC_ADDR_MOD_LO: begin
                    mod_lo_buf_d = i_wdata;
                    if (mod_half_q[1]) begin
                        mod_d = {mod_hi_buf_q, i_wdata};
                        mod_half_d = 2'b00;
                    end else begin
                        mod_half_d = 2'b01;
                    end
                end
                `TMC_ADDR_MOD_HI: begin
                    mod_hi_buf_d = i_wdata;
                    if (mod_half_q[0]) begin
                        mod_d = {i_wdata, mod_lo_buf_q};
                        mod_half_d = 2'b00;
                    end else begin
                        mod_half_d = 2'b10;
                    end
                end
                `TMC_ADDR_CHSC: begin
                    ie_d = i_wdata[`TMC_BIT_IE];
                    ms_d = i_wdata[`TMC_BIT_MSB:`TMC_BIT_MSA];
                    els_d = i_wdata[`TMC_BIT_ELSB:`TMC_BIT_ELSA];
                    if (!i_wdata[`TMC_BIT_FLAG] && flag_armed_q) begin
                        flag_d = 1'b0;
                    end
                    flag_armed_d = 1'b0;
                    chval_half_d = 2'b00;
                end
                `TMC_ADDR_CHVAL_LO: begin
                    chval_lo_buf_d = i_wdata;
                    chval_half_d = chval_half_q | 2'b01;
                end
                `TMC_ADDR_CHVAL_HI: begin
                    chval_d = {i_wdata, chval_lo_buf_q};
                    chval_half_d = 2'b00;
                end
                `TMC_ADDR_CNT_LO, `TMC_ADDR_CNT_HI: begin
                    cnt_d = 16'h0000;  // any counter write resets it
                    down_d = 1'b0;
                end
                default: begin
                end
            endcase
        end

        if (event_hit) begin
            flag_d = 1'b1;
            flag_armed_d = 1'b0;
        end
        // capture stores counter value
        if (event_hit && mode == TMC_MODE_CAPTURE) begin
            chval_d = cnt_q;
        end
        if (ovf_hit && !mod_inhibit) begin
            ovf_d = 1'b1;
            ovf_armed_d = 1'b0;
        end
    end

    // register update
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mod_q <= `TMC_MOD_RESET;
            mod_lo_buf_q <= 8'h00;
            mod_hi_buf_q <= 8'h00;
            mod_half_q <= 2'b00;
            cnt_q <= 16'h0000;
            down_q <= 1'b0;
            ovf_q <= 1'b0;
            ovf_armed_q <= 1'b0;
            ovf_ie_q <= 1'b0;
            cpwm_q <= 1'b0;
            flag_q <= 1'b0;
            flag_armed_q <= 1'b0;
            ie_q <= 1'b0;
            ms_q <= 2'b00;
            els_q <= 2'b00;
            chval_q <= 16'h0000;
            chval_lo_buf_q <= 8'h00;
            chval_half_q <= 2'b00;
            pin_q <= 1'b0;
            rdata_q <= 8'h00;
            sync_q <= 3'b000;
            pin_prev_q <= 1'b0;
            pre_q <= 8'h00;
        end else begin
            mod_q <= mod_d;
            mod_lo_buf_q <= mod_lo_buf_d;
            mod_hi_buf_q <= mod_hi_buf_d;
            mod_half_q <= mod_half_d;
            cnt_q <= cnt_d;
            down_q <= down_d;
            ovf_q <= ovf_d;
            ovf_armed_q <= ovf_armed_d;
            ovf_ie_q <= ovf_ie_d;
            cpwm_q <= cpwm_d;
            flag_q <= flag_d;
            flag_armed_q <= flag_armed_d;
            ie_q <= ie_d;
            ms_q <= ms_d;
            els_q <= els_d;
            chval_q <= chval_d;
            chval_lo_buf_q <= chval_lo_buf_d;
            chval_half_q <= chval_half_d;
            pin_q <= pin_d;
            rdata_q <= rdata_d;
            sync_q <= sync_d;
            pin_prev_q <= pin_prev_d;
            pre_q <= pre_d;
        end
    end

    // outputs; pin drive only in output modes
    always_comb begin
        o_rdata = rdata_q;
        o_ch_pin = pin_q;
        o_ch_pin_oe_n = !(mode == TMC_MODE_COMPARE && els_q != 2'b00) &&
                        !(mode == TMC_MODE_EPWM) && !(mode == TMC_MODE_CPWM);
        o_ch_irq = flag_q && ie_q;
        o_ovf_irq = ovf_q && ovf_ie_q;
        o_mode = mode;
    end
endmodule : tmc_timer_channel

// File: bench/tmc_checker.sv
// concurrent checks on the ports of the timer channel block
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_checker (
    input wire logic               i_clk,
    input wire logic               i_rst,
    input wire logic [3:0]         i_addr,
    input wire logic [7:0]         i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [7:0]         o_rdata,
    input wire logic               i_ch_pin,
    input wire logic               o_ch_pin,
    input wire logic               o_ch_pin_oe_n,
    input wire logic               o_ch_irq,
    input wire logic               o_ovf_irq,
    input wire tmc_pkg::tmc_mode_e o_mode
);
    import tmc_pkg::*;
    logic       cpwm_q; // centre select as last written
    logic [6:2] sc_q;   // channel control as last written
    logic       lo_q;   // modulo low byte written
    logic       hi_q;   // modulo high byte written
    // shadows follow software writes only; flags are left to the design
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cpwm_q <= 1'b0;
            sc_q   <= '0;
            lo_q   <= 1'b0;
            hi_q   <= 1'b0;
        end else begin
            if (i_wr && i_addr == `TMC_ADDR_CTRL) begin
                cpwm_q <= i_wdata[`TMC_BIT_CPWM];
            end
            if (i_wr && i_addr == `TMC_ADDR_CHSC) begin
                sc_q <= i_wdata[6:2];
            end
            // both set for one cycle marks the commit, then both drop
            lo_q <= (lo_q & ~hi_q) | (i_wr && i_addr == `TMC_ADDR_MOD_LO);
            hi_q <= (hi_q & ~lo_q) | (i_wr && i_addr == `TMC_ADDR_MOD_HI);
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // rising-only capture with request enabled
    sequence s_cap_edge;
        o_mode == TMC_MODE_CAPTURE && sc_q == 5'b10001 && $rose(i_ch_pin);
    endsequence
    // pin held long enough to pass the synchroniser
    sequence s_pin_held;
        (i_ch_pin && !i_wr) [*4];
    endsequence
    AST_CAPTURE_RISE: assert property (s_cap_edge ##1 s_pin_held |-> ##[0:4] o_ch_irq)
        else $error("capture edge raised no request");
    AST_IRQ_NEEDS_IE: assert property (o_ch_irq |-> sc_q[6])
        else $error("channel request without enable");
    AST_IRQ_FALL: assert property (
        $fell(o_ch_irq) |-> $past(i_wr) && $past(i_addr) == `TMC_ADDR_CHSC)
        else $error("channel request dropped without a write");
    AST_OVF_INHIBIT: assert property (
        (lo_q ^ hi_q) && $past(lo_q ^ hi_q) && !$past(i_wr) |-> !$rose(o_ovf_irq))
        else $error("overflow set with one modulo byte pending");
    AST_EPWM_MODE: assert property (
        !cpwm_q && sc_q[5] && sc_q[3:2] != 2'b00 |-> o_mode == TMC_MODE_EPWM)
        else $error("mode b did not give edge pwm");
    AST_CAP_CMP_MODE: assert property (
        !cpwm_q && !sc_q[5] && sc_q[3:2] != 2'b00
        |-> o_mode == (sc_q[4] ? TMC_MODE_COMPARE : TMC_MODE_CAPTURE))
        else $error("mode a did not pick capture or compare");
    AST_PIN_RELEASE: assert property (
        sc_q[3:2] == 2'b00 && $past(sc_q[3:2]) == 2'b00 |-> o_ch_pin_oe_n)
        else $error("pin driven with edge level zero");
    AST_OE_DRIVE: assert property (
        o_mode != TMC_MODE_CAPTURE && o_mode != TMC_MODE_OFF && sc_q[3:2] != 2'b00
        |-> ##[0:1] !o_ch_pin_oe_n)
        else $error("output mode left the pin undriven");
endmodule : tmc_checker
bind tmc_timer_channel tmc_checker tmc_checker_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_ch_pin(i_ch_pin), .o_ch_pin(o_ch_pin),
    .o_ch_pin_oe_n(o_ch_pin_oe_n), .o_ch_irq(o_ch_irq), .o_ovf_irq(o_ovf_irq),
    .o_mode(o_mode)
);

// File: bench/tmc_pin_model.sv
// far-side circuit on the channel pin, resolves the wire level
`timescale 1ns/1ps
module tmc_pin_model (
    input  wire logic i_clk,
    input  wire logic i_drv_en,   // far side drives the wire
    input  wire logic i_drv_lvl,  // level the far side drives
    input  wire logic i_blk_pin,  // block output level
    input  wire logic i_blk_oe_n, // block drives when low
    output logic      o_wire      // level seen by everyone
);
    logic flip_q = 1'b0; // no pull on this wire, so an idle wire wanders
    always_ff @(posedge i_clk) begin
        flip_q <= ~flip_q;
    end
    // the block owns the wire only while its enable is low
    assign o_wire = !i_blk_oe_n ? i_blk_pin : (i_drv_en ? i_drv_lvl : flip_q);
endmodule : tmc_pin_model

// File: bench/tb.sv
// self-checking testbench for the timer channel block
`timescale 1ns/1ps
`include "tmc_map.svh"
module tb;
    import tmc_pkg::*;
    logic       i_clk, i_rst, i_wr, i_rd, i_ch_pin, o_ch_pin, o_ch_pin_oe_n;
    logic       o_ch_irq, o_ovf_irq, drv_lvl;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, rv;
    tmc_mode_e  o_mode;
    int         bad_count = 0;
    int         samples_checked = 0;
    int         cyc = 0;
    // short prescale keeps every count at one bus clock
    tmc_timer_channel #(.PRESCALE(1)) tmc_timer_channel_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ch_pin(i_ch_pin), .o_ch_pin(o_ch_pin), .o_ch_pin_oe_n(o_ch_pin_oe_n),
        .o_ch_irq(o_ch_irq), .o_ovf_irq(o_ovf_irq), .o_mode(o_mode));
    tmc_pin_model tmc_pin_model_inst (.i_clk(i_clk), .i_drv_en(1'b1), .i_drv_lvl(drv_lvl),
        .i_blk_pin(o_ch_pin), .i_blk_oe_n(o_ch_pin_oe_n), .o_wire(i_ch_pin));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) cyc <= cyc + 1;
    task chk(input logic [15:0] s, input logic [15:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        rv = o_rdata;
    endtask : rd
    // flag clear: read it set, then write zero to it
    task clr();
        rd(`TMC_ADDR_CHSC);
        wr(`TMC_ADDR_CHSC, {1'b0, rv[6:0]});
    endtask : clr
    task wirq();
        for (int n = 0; n < 80 && o_ch_irq !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
    endtask : wirq
    task pin(input logic v);
        @(posedge i_clk);
        drv_lvl <= v;
        repeat (8) @(posedge i_clk);
        #1;
    endtask : pin
    // counter restarted before both modulo bytes are written
    task setmod(input logic [7:0] m);
        wr(`TMC_ADDR_CNT_LO, 8'h00);
        wr(`TMC_ADDR_MOD_LO, m);
        wr(`TMC_ADDR_MOD_HI, 8'h00);
    endtask : setmod
    // largest count seen, and whether it fell twice in a row
    task scan(output logic [7:0] mx, output logic dn);
        logic [7:0] pv;
        int run;
        mx = 8'h00;
        dn = 1'b0;
        pv = 8'h00;
        run = 0;
        repeat (40) begin
            rd(`TMC_ADDR_CNT_LO);
            mx = (rv > mx) ? rv : mx;
            run = (rv < pv) ? run + 1 : 0;
            dn = dn | (run > 1);
            pv = rv;
            rd(`TMC_ADDR_CNT_HI);
        end
    endtask : scan
    task t_reset();
        rd(`TMC_ADDR_MOD_LO);
        chk(rv, 8'h00);
        rd(`TMC_ADDR_MOD_HI);
        chk(rv, 8'h00);
        rd(`TMC_ADDR_CHSC);
        chk(rv, 8'h00);
        rd(4'hf);
        chk(rv, 8'h00);
        wr(`TMC_ADDR_CNT_LO, 8'h00);
        repeat (300) @(posedge i_clk);
        rd(`TMC_ADDR_CNT_HI);
        chk(rv, 8'h01);
        wr(`TMC_ADDR_CHSC, 8'h4c);
        rd(`TMC_ADDR_CHSC);
        chk(rv, 8'h4c);
    endtask : t_reset
    task t_mod();
        logic [7:0] mx;
        logic dn;
        wr(`TMC_ADDR_CTRL, 8'h40);
        setmod(8'h10);
        scan(mx, dn);
        chk(mx, 8'h10);
        chk(dn, 1'b0);
        chk(o_ovf_irq, 1'b1);
        // with one byte pending no overflow may race the clear
        wr(`TMC_ADDR_MOD_LO, 8'h20);
        rd(`TMC_ADDR_CTRL);
        wr(`TMC_ADDR_CTRL, 8'h40);
        repeat (40) @(posedge i_clk);
        chk(o_ovf_irq, 1'b0);
        wr(`TMC_ADDR_MOD_HI, 8'h00);
        repeat (40) @(posedge i_clk);
        chk(o_ovf_irq, 1'b1);
        wr(`TMC_ADDR_CTRL, 8'h60);
        scan(mx, dn);
        chk(dn, 1'b1);
        wr(`TMC_ADDR_CTRL, 8'h00);
    endtask : t_mod
    task t_cap();
        for (logic [2:0] e = 3'd1; e < 3'd4; e++) begin
            wr(`TMC_ADDR_CHSC, {4'h4, e[1:0], 2'b00});
            clr();
            pin(1'b1);
            chk(o_ch_irq, e[0]);
            clr();
            chk(o_ch_irq, 1'b0);
            pin(1'b0);
            chk(o_ch_irq, e[1]);
            clr();
        end
        wr(`TMC_ADDR_CHSC, 8'h44);
        clr();
        pin(1'b1);
        rd(`TMC_ADDR_CHSC);
        pin(1'b0);
        pin(1'b1);
        wr(`TMC_ADDR_CHSC, 8'h44);
        chk(o_ch_irq, 1'b1);
        clr();
        wr(`TMC_ADDR_CHSC, 8'hc4);
        chk(o_ch_irq, 1'b0);
        wr(`TMC_ADDR_CHSC, 8'h04);
        pin(1'b0);
        pin(1'b1);
        chk(o_ch_irq, 1'b0);
        rd(`TMC_ADDR_CHSC);
        chk(rv[7], 1'b1);
    endtask : t_cap
    // compare late in the period so setup never meets a match
    task t_cmp();
        wr(`TMC_ADDR_CHVAL_LO, 8'h18);
        wr(`TMC_ADDR_CHVAL_HI, 8'h00);
        for (logic [2:0] e = 3'd3; e > 3'd0; e--) begin
            wr(`TMC_ADDR_CNT_LO, 8'h00);
            wr(`TMC_ADDR_CHSC, {4'h5, e[1:0], 2'b00});
            clr();
            wirq();
            chk(o_ch_irq, 1'b1);
            repeat (2) @(posedge i_clk);
            #1;
            chk(o_ch_pin, e != 3'd2);
            chk(o_ch_pin_oe_n, 1'b0);
            chk(o_mode, TMC_MODE_COMPARE);
        end
        // software compare: field zero still flags, pin stays free
        wr(`TMC_ADDR_CNT_LO, 8'h00);
        // field zero leaves the pin to the far-side driver
        wr(`TMC_ADDR_CHSC, 8'h50);
        clr();
        wirq();
        chk(o_ch_irq, 1'b1);
        chk(o_ch_pin_oe_n, 1'b1);
    endtask : t_cmp
    task t_pwm();
        int hi;
        int t0;
        setmod(8'h10);
        wr(`TMC_ADDR_CHVAL_LO, 8'h08);
        wr(`TMC_ADDR_CHVAL_HI, 8'h00);
        for (logic [2:0] e = 3'd1; e < 3'd3; e++) begin
            wr(`TMC_ADDR_CHSC, {4'h2, e[1:0], 2'b00});
            repeat (40) @(posedge i_clk);
            hi = 0;
            // four whole periods of seventeen counts
            repeat (68) begin
                @(negedge i_clk);
                hi += int'(o_ch_pin);
            end
            chk(16'(hi), e[0] ? 16'd32 : 16'd36);
            chk(o_mode, TMC_MODE_EPWM);
        end
        wr(`TMC_ADDR_CTRL, 8'h20);
        wr(`TMC_ADDR_CHSC, 8'h68);
        // first clear may meet a match, so align to a real one first
        clr();
        wirq();
        clr();
        wirq();
        t0 = cyc;
        clr();
        wirq();
        chk(16'(cyc - t0), 16'd16);
    endtask : t_pwm
    task give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        {i_rst, i_addr, i_wdata, i_wr, i_rd, drv_lvl} = {1'b1, 4'h0, 8'h00, 3'b000};
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_mod();
        t_cap();
        t_cmp();
        t_pwm();
        give_verdict();
    end
endmodule : tb
